// ===== include/cpu_ops_pkg.sv
// shared constants for the cpu operation datapath
package cpu_ops_pkg;
  // ****************************************
  // widths and address limits
  // ****************************************
  localparam int WORD_W       = 16;
  localparam int REG_W        = 20;
  localparam logic [19:0] SHORT_LIMIT = 20'h0ffff;  // 64KB reach of subroutine ops
  localparam logic [19:0] STACK_STEP  = 20'h00002;
  // status word bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [19:0] SP_RESET     = 20'h00000;
  localparam logic [19:0] IP_RESET     = 20'h00000;
  // addressing mode codes of an operand
  localparam logic [2:0] AM_REG = 3'h0;
  localparam logic [2:0] AM_IDX = 3'h1;
  localparam logic [2:0] AM_SYM = 3'h2;
  localparam logic [2:0] AM_ABS = 3'h3;
  localparam logic [2:0] AM_IND = 3'h4;
  localparam logic [2:0] AM_INC = 3'h5;
  localparam logic [2:0] AM_IMM = 3'h6;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [4:0] {
    copy_op              = 5'h00,
    sum_op               = 5'h01,
    sum_with_carry_in    = 5'h02,
    difference_op        = 5'h03,
    minus_with_carry_op  = 5'h04,
    compare_op           = 5'h05,
    decimal_sum_op       = 5'h06,
    test_mask_op         = 5'h07,
    clear_mask_op        = 5'h08,
    set_mask_op          = 5'h09,
    exclusive_or_op      = 5'h0a,
    conjunction_op       = 5'h0b,
    rotate_right_thru_carry = 5'h10,
    arith_shift_right    = 5'h11,
    stack_store_op       = 5'h12,
    byte_swap_op         = 5'h13,
    subroutine_jump_op   = 5'h14,
    interrupt_return_op  = 5'h15,
    sign_extend_op       = 5'h16,
    subroutine_return_op = 5'h17
  } op_e;
endpackage

// ===== rtl/bcd_adder.sv
// packed decimal adder, one generate stage per digit
`timescale 1ns/100ps
module bcd_adder #(
  parameter int DIGITS = 4
) (
  // operands
  input  wire logic [4*DIGITS-1:0] a,
  input  wire logic [4*DIGITS-1:0] b,
  input  wire logic                carryIn,
  // result
  output logic      [4*DIGITS-1:0] sum,
  output logic                     carryOut
);
  initial begin
    if (DIGITS < 1) $error("bcd_adder needs at least one digit");
  end

  logic [DIGITS:0] chain;
  assign chain[0] = carryIn;

  // each digit adds binary, then corrects by six above nine
  for (genvar d = 0; d < DIGITS; d++) begin : g_digit
    logic [4:0] raw;
    logic       over;
    assign raw  = {1'b0, a[4*d+:4]} + {1'b0, b[4*d+:4]} + {4'h0, chain[d]};
    assign over = (raw > 5'h09);
    assign sum[4*d+:4] = over ? 4'((raw + 5'h06) & 5'h0f) : raw[3:0];
    assign chain[d+1]  = over;
  end

  assign carryOut = chain[DIGITS];
endmodule // bcd_adder

// ===== rtl/cpu_op_unit.sv
// execution unit for the core two-operand and one-operand operations
`timescale 1ns/100ps
module cpu_op_unit
  import cpu_ops_pkg::*;
#(
  parameter int DATA_W = REG_W
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // request
  input  wire logic              start,
  input  wire logic [4:0]        opCode,
  input  wire logic              byteMode,
  input  wire logic [2:0]        srcMode,
  input  wire logic [2:0]        dstMode,
  input  wire logic [19:0]       srcValue,
  input  wire logic [19:0]       dstValue,
  input  wire logic [15:0]       stackReadData,
  // results
  output logic                   done,
  output logic [19:0]            result,
  output logic                   writeDst,
  output logic [1:0]             extraWords,
  output logic [15:0]            statusWord,
  output logic [19:0]            stackPointer,
  output logic [19:0]            instructionPointer,
  output logic                   stackWrite,
  output logic                   stackRead,
  output logic [19:0]            stackAddr,
  output logic [15:0]            stackWriteData
);
  initial begin
    if (DATA_W != REG_W) $error("cpu_op_unit supports only 20-bit registers");
  end

  // ****************************************
  // sequencing
  // ****************************************
  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    POP_SR  = 2'b01,
    POP_IP  = 2'b10,
    POP_RET = 2'b11
  } seq_e;
  seq_e state;

  // ****************************************
  // combinational arithmetic
  // ****************************************
  logic [19:0] a, b, r;
  logic        cIn, cOut, vOut, updFlags, logicCarry, clrV, keepV, store;
  logic [19:0] msbMask, opMask;
  logic [15:0] bcdSum;
  logic        bcdCarry;
  logic [20:0] wide;
  logic        topBit, aTop, bTop;
  logic [19:0] next_result;

  bcd_adder #(.DIGITS(4)) u_bcd (
    .a        (a[15:0]),
    .b        (b[15:0]),
    .carryIn  (statusWord[FLAG_C]),
    .sum      (bcdSum),
    .carryOut (bcdCarry)
  );

  // byte ops narrow operands to low 8 bits, word ops to 16
  always_comb begin
    msbMask = byteMode ? 20'h00080 : 20'h08000;
    // carry out of the operand width must not reach the result or the zero test
    opMask = byteMode ? 20'h000ff : 20'h0ffff;
    a = byteMode ? {12'h000, srcValue[7:0]} : {4'h0, srcValue[15:0]};
    b = byteMode ? {12'h000, dstValue[7:0]} : {4'h0, dstValue[15:0]};
    cIn = statusWord[FLAG_C];
  end

  // one result mux per opcode with its flag policy
  always_comb begin
    wide = 21'h000000;
    r = b;
    cOut = cIn;
    updFlags = 1'b0;
    logicCarry = 1'b0;
    clrV = 1'b0;
    keepV = 1'b0;
    store = 1'b1;
    unique case (opCode)
      copy_op: r = a;
      sum_op, sum_with_carry_in: begin
        wide = {1'b0, a} + {1'b0, b} + {20'h00000, (opCode == sum_with_carry_in) & cIn};
        r = wide[19:0] & opMask;
        updFlags = 1'b1;
      end
      difference_op, minus_with_carry_op, compare_op: begin
        wide = {1'b0, b} + {1'b0, ~a & (byteMode ? 20'h000ff : 20'h0ffff)}
             + {20'h00000, (opCode == minus_with_carry_op) ? cIn : 1'b1};
        r = wide[19:0] & opMask;
        updFlags = 1'b1;
        store = (opCode != compare_op);
      end
      decimal_sum_op: begin
        r = byteMode ? {12'h000, bcdSum[7:0]} : {4'h0, bcdSum};
        updFlags = 1'b1;
      end
      test_mask_op, conjunction_op: begin
        r = a & b;
        updFlags = 1'b1;
        logicCarry = 1'b1;
        clrV = 1'b1;
        store = (opCode == conjunction_op);
      end
      clear_mask_op: r = ~a & b;
      set_mask_op: r = a | b;
      exclusive_or_op: begin
        r = a ^ b;
        updFlags = 1'b1;
        logicCarry = 1'b1;
      end
      rotate_right_thru_carry: begin
        r = (b >> 1) | (cIn ? msbMask : 20'h00000);
        cOut = b[0];
        updFlags = 1'b1;
        clrV = 1'b1;
        keepV = 1'b1;
      end
      arith_shift_right: begin
        r = (b >> 1) | (b & msbMask);
        cOut = b[0];
        updFlags = 1'b1;
        clrV = 1'b1;
        keepV = 1'b1;
      end
      byte_swap_op: r = {4'h0, dstValue[7:0], dstValue[15:8]};
      sign_extend_op: begin
        if (dstMode == AM_REG) r = {{12{dstValue[7]}}, dstValue[7:0]};
        else r = {4'h0, {8{dstValue[7]}}, dstValue[7:0]};
        updFlags = 1'b1;
        logicCarry = 1'b1;
        clrV = 1'b1;
      end
      default: store = 1'b0;
    endcase
  end

  // top bits for the two's complement overflow
  always_comb begin
    topBit = |(r & msbMask);
    aTop = |(a & msbMask);
    bTop = |(b & msbMask);
    vOut = 1'b0;
    if (opCode == sum_op || opCode == sum_with_carry_in)
      vOut = (aTop == bTop) && (topBit != aTop);
    else if (opCode == difference_op || opCode == minus_with_carry_op || opCode == compare_op)
      vOut = (aTop != bTop) && (topBit != bTop);
    else if (opCode == exclusive_or_op)
      vOut = aTop && bTop; // both operands negative
    next_result = r;
  end

  // ****************************************
  // extra word count from addressing modes
  // ****************************************
  function automatic logic needsWord(input logic [2:0] m);
    needsWord = (m == AM_IDX) || (m == AM_SYM) || (m == AM_ABS) || (m == AM_IMM);
  endfunction

  always_ff @(posedge clk) begin
    if (reset) extraWords <= 2'h0;
    else if (start && state == IDLE) begin
      if (opCode < 5'h10) extraWords <= {1'b0, needsWord(srcMode)} + {1'b0, needsWord(dstMode)};
      else if (opCode == interrupt_return_op || opCode == subroutine_return_op) extraWords <= 2'h0;
      else extraWords <= {1'b0, needsWord(dstMode)};
    end
  end

  // ****************************************
  // result, store strobe and done
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      result   <= 20'h00000;
      writeDst <= 1'b0;
      done     <= 1'b0;
    end else begin
      writeDst <= 1'b0;
      done     <= 1'b0;
      if (start && state == IDLE && opCode != interrupt_return_op && opCode != subroutine_return_op) begin
        result   <= next_result;
        writeDst <= store;
        done     <= 1'b1;
      end else if (state == POP_IP || state == POP_RET) done <= 1'b1;
    end
  end

  // ****************************************
  // status word; flags from the narrowed top bit
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) statusWord <= STATUS_RESET;
    else if (state == POP_SR) statusWord <= stackReadData;
    else if (start && state == IDLE && updFlags) begin
      statusWord[FLAG_N] <= topBit;
      statusWord[FLAG_Z] <= (r == 20'h00000);
      if (logicCarry) statusWord[FLAG_C] <= (r != 20'h00000);
      // upper digits are zero in byte mode, so bit 8 holds the byte's decimal carry
      else if (opCode == decimal_sum_op) statusWord[FLAG_C] <= byteMode ? bcdSum[8] : bcdCarry;
      else if (keepV) statusWord[FLAG_C] <= cOut;
      else statusWord[FLAG_C] <= byteMode ? wide[8] : wide[16];
      statusWord[FLAG_V] <= clrV ? 1'b0 : vOut;
    end
  end

  // ****************************************
  // stack and instruction pointer sequencing
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state              <= IDLE;
      stackPointer       <= SP_RESET;
      instructionPointer <= IP_RESET;
      stackWrite         <= 1'b0;
      stackRead          <= 1'b0;
      stackAddr          <= 20'h00000;
      stackWriteData     <= 16'h0000;
    end else begin
      stackWrite <= 1'b0;
      stackRead  <= 1'b0;
      unique case (state)
        IDLE: if (start) begin
          if (opCode == stack_store_op) begin
            stackPointer   <= stackPointer - STACK_STEP;
            stackAddr      <= stackPointer - STACK_STEP;
            stackWriteData <= byteMode ? {8'h00, srcValue[7:0]} : srcValue[15:0];
            stackWrite     <= 1'b1;
          end else if (opCode == subroutine_jump_op) begin
            stackPointer       <= stackPointer - STACK_STEP;
            stackAddr          <= stackPointer - STACK_STEP;
            stackWriteData     <= instructionPointer[15:0];
            stackWrite         <= 1'b1;
            instructionPointer <= dstValue & SHORT_LIMIT;
          end else if (opCode == interrupt_return_op) begin
            stackAddr <= stackPointer;
            stackRead <= 1'b1;
            state     <= POP_SR;
          end else if (opCode == subroutine_return_op) begin
            stackAddr <= stackPointer;
            stackRead <= 1'b1;
            state     <= POP_RET;
          end
        end
        POP_SR: begin
          stackPointer <= stackPointer + STACK_STEP;
          stackAddr    <= stackPointer + STACK_STEP;
          stackRead    <= 1'b1;
          state        <= POP_IP;
        end
        POP_IP: begin
          instructionPointer <= {4'h0, stackReadData};
          stackPointer       <= stackPointer + STACK_STEP;
          state              <= IDLE;
        end
        POP_RET: begin
          instructionPointer <= {4'h0, stackReadData} & SHORT_LIMIT;
          stackPointer       <= stackPointer + STACK_STEP;
          state              <= IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_copy_flags: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == copy_op) |=> $stable(statusWord))
    else $error("copy changed flags");
  a_sum_value: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == sum_op && !byteMode) |=>
    result[15:0] == 16'($past(srcValue[15:0]) + $past(dstValue[15:0])))
    else $error("sum result wrong");
  a_cmp_nostore: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && (opCode == compare_op || opCode == test_mask_op)) |=> !writeDst)
    else $error("compare stored");
  a_and_carry: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == conjunction_op) |=>
    statusWord[FLAG_C] == !statusWord[FLAG_Z] && !statusWord[FLAG_V])
    else $error("and flags wrong");
  a_mask_flags: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && (opCode == clear_mask_op || opCode == set_mask_op)) |=> $stable(statusWord))
    else $error("mask op changed flags");
  a_push_sp: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == stack_store_op) |=>
    stackWrite && stackPointer == $past(stackPointer) - STACK_STEP && stackAddr == stackPointer)
    else $error("push stack wrong");
  a_swap_value: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == byte_swap_op) |=>
    result[15:0] == {$past(dstValue[7:0]), $past(dstValue[15:8])})
    else $error("swap wrong");
  a_interrupt_return_op_sp: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == interrupt_return_op) |=>
    ##2 stackPointer == $past(stackPointer, 3) + 20'h00004)
    else $error("interrupt return stack wrong");
  a_short_ip: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == subroutine_jump_op) |=> instructionPointer <= SHORT_LIMIT)
    else $error("call beyond 64KB");
  a_xor_carry: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == exclusive_or_op) |=> statusWord[FLAG_C] == !statusWord[FLAG_Z])
    else $error("xor carry wrong");
  a_interrupt_return_op_done: assert property (@(posedge clk) disable iff (reset)
    (start && state == IDLE && opCode == interrupt_return_op) |=> !done ##1 !done ##1 done)
    else $error("interrupt return done late");
  c_sum: cover property (@(posedge clk) start && state == IDLE && opCode == sum_op);
  c_interrupt_return_op: cover property (@(posedge clk) state == POP_IP);
  c_push: cover property (@(posedge clk) stackWrite);
  c_ret: cover property (@(posedge clk) state == POP_RET);
  c_byte: cover property (@(posedge clk) start && state == IDLE && byteMode);
endmodule // cpu_op_unit

// ===== verification/cpu_double_single_operand_ops_test.sv
// self-checking bench for the cpu operation execution unit
`timescale 1ns/100ps
module cpu_double_single_operand_ops_test
  import cpu_ops_pkg::*;
;
  // ****************************************
  // signals and bench state
  // ****************************************
  typedef struct {
    op_e op; logic byt; logic [2:0] dm; logic [19:0] src, dst, res, msk; logic wr, keep; logic [3:0] vnzc;
  } case_s;
  logic        clk, reset, start, byteMode, done, writeDst, stackWrite, stackRead;
  logic [4:0]  opCode;
  logic [2:0]  srcMode, dstMode;
  logic [19:0] srcValue, dstValue, result, stackPointer, instructionPointer, stackAddr, wrAddr;
  logic [15:0] stackReadData, statusWord, stackWriteData, wrData;
  logic [1:0]  extraWords;
  logic [15:0] popWords [2];
  logic [19:0] rdAddr [4];
  logic [3:0]  expF;
  logic        sawWr, gotDone, wdAtDone;
  int          failCount, numChecks, sawRd, popIdx;
  case_s       cs [22];

  cpu_op_unit uut (.clk(clk), .reset(reset), .start(start), .opCode(opCode), .byteMode(byteMode),
    .srcMode(srcMode), .dstMode(dstMode), .srcValue(srcValue), .dstValue(dstValue),
    .stackReadData(stackReadData), .done(done), .result(result), .writeDst(writeDst),
    .extraWords(extraWords), .statusWord(statusWord), .stackPointer(stackPointer),
    .instructionPointer(instructionPointer), .stackWrite(stackWrite), .stackRead(stackRead),
    .stackAddr(stackAddr), .stackWriteData(stackWriteData));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_flags();
    chk({16'h0000, statusWord[FLAG_V], statusWord[FLAG_N], statusWord[FLAG_Z], statusWord[FLAG_C]}, {16'h0000, expF});
  endtask

  function automatic logic [1:0] ext(input logic [2:0] m);
    return (m == AM_IDX || m == AM_SYM || m == AM_ABS || m == AM_IMM) ? 2'h1 : 2'h0;
  endfunction

  // one operation; a stack read is answered before the next edge, idle data is inverted
  task automatic run_op(input op_e op, input logic byt, input logic [2:0] sm, input logic [2:0] dm,
                        input logic [19:0] s, input logic [19:0] d);
    int n;
    n = 0;
    opCode = op; byteMode = byt; srcMode = sm; dstMode = dm; srcValue = s; dstValue = d; start = 1'b1;
    sawWr = 1'b0; sawRd = 0; popIdx = 0; gotDone = 1'b0; wdAtDone = 1'b0;
    @(negedge clk);
    start = 1'b0;
    while (!gotDone && n < 8) begin
      if (stackWrite === 1'b1) begin
        sawWr = 1'b1; wrAddr = stackAddr; wrData = stackWriteData;
      end
      if (stackRead === 1'b1 && sawRd < 4) begin
        rdAddr[sawRd] = stackAddr;
        sawRd++;
      end
      if (stackRead === 1'b1 && popIdx < 2) begin
        stackReadData = popWords[popIdx];
        popIdx++;
      end else stackReadData = ~stackReadData;
      gotDone = (done === 1'b1);
      wdAtDone = (writeDst === 1'b1);
      n++;
      if (!gotDone) @(negedge clk);
    end
    chk({19'h0, gotDone}, 20'h00001);
    // start stays low for one edge so that no call lowers and raises it in one time step
    @(negedge clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // extension-word count for every source mode against register and indexed destinations, flags must stay cleared
  task automatic t_extra_words();
    for (int s = 0; s < 7; s++) begin
      for (int d = 0; d < 2; d++) begin
        run_op(copy_op, 1'b0, s[2:0], d[2:0], 20'h00042, 20'h00000);
        chk({18'h0, extraWords}, {18'h0, ext(s[2:0]) + ext(d[2:0])});
      end
      run_op(byte_swap_op, 1'b0, s[2:0], s[2:0], 20'h0a55a, 20'h0a55a);
      chk({18'h0, extraWords}, {18'h0, ext(s[2:0])});
    end
    chk_flags();
  endtask

  // result, store strobe and flags of each arithmetic and logic operation in chained order
  task automatic t_alu_table();
    for (int i = 0; i < 22; i++) begin
      run_op(cs[i].op, cs[i].byt, cs[i].dm, cs[i].dm, cs[i].src, cs[i].dst);
      if (!cs[i].keep) expF = cs[i].vnzc;
      chk({19'h0, wdAtDone}, {19'h0, cs[i].wr});
      if (cs[i].wr) chk(result & cs[i].msk, cs[i].res);
      chk_flags();
    end
  endtask

  // push, then interrupt return pops status and pointer, stack pointer wraps at zero
  task automatic t_stack();
    run_op(stack_store_op, 1'b0, AM_REG, AM_REG, 20'h00abc, 20'h00abc);
    chk({19'h0, sawWr}, 20'h00001);
    chk(wrAddr, SP_RESET - STACK_STEP);
    chk({4'h0, wrData}, 20'h00abc);
    chk(stackPointer, SP_RESET - STACK_STEP);
    chk_flags();
    popWords[0] = 16'h0105;
    popWords[1] = 16'h1234;
    run_op(interrupt_return_op, 1'b0, AM_IDX, AM_IDX, 20'h00000, 20'h00000);
    chk(rdAddr[0], SP_RESET - STACK_STEP);
    chk({4'h0, statusWord}, 20'h00105);
    chk(rdAddr[1], SP_RESET);
    chk(instructionPointer, 20'h01234);
    chk(stackPointer, SP_RESET + STACK_STEP);
    chk(20'(sawRd), 20'h00002);
    chk({18'h0, extraWords}, 20'h00000);
    expF = 4'b1101;
  endtask

  // subroutine jump and return stay inside the lower 64KB, flags untouched
  task automatic t_subroutine();
    run_op(subroutine_jump_op, 1'b0, AM_REG, AM_REG, 20'h5abcd, 20'h5abcd);
    chk(instructionPointer, 20'h5abcd & SHORT_LIMIT);
    chk({4'h0, wrData}, 20'h01234);
    chk(stackPointer, SP_RESET);
    chk_flags();
    popWords[0] = 16'h8000;
    run_op(subroutine_return_op, 1'b0, AM_REG, AM_REG, 20'h00000, 20'h00000);
    chk(rdAddr[0], SP_RESET);
    chk(instructionPointer, 20'h08000);
    chk(20'(sawRd), 20'h00001);
    chk(stackPointer, SP_RESET + STACK_STEP);
    chk_flags();
  endtask

  task automatic printVerdict();
    $display("checks=%0d mismatches=%0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    printVerdict();
  end

  initial begin
    // flags chain row to row: each row assumes the flags left by the row above
    cs[0]  = '{copy_op, 1'b0, AM_REG, 20'h01234, 20'h00000, 20'h01234, 20'h0ffff, 1'b1, 1'b1, 4'b0000};
    cs[1]  = '{sum_op, 1'b0, AM_REG, 20'h00001, 20'h07fff, 20'h08000, 20'h0ffff, 1'b1, 1'b0, 4'b1100};
    cs[2]  = '{sum_op, 1'b0, AM_REG, 20'h00001, 20'h0ffff, 20'h00000, 20'h0ffff, 1'b1, 1'b0, 4'b0011};
    cs[3]  = '{sum_with_carry_in, 1'b0, AM_REG, 20'h00001, 20'h00001, 20'h00003, 20'h0ffff, 1'b1, 1'b0, 4'b0000};
    cs[4]  = '{difference_op, 1'b0, AM_REG, 20'h00005, 20'h00005, 20'h00000, 20'h0ffff, 1'b1, 1'b0, 4'b0011};
    cs[5]  = '{compare_op, 1'b0, AM_REG, 20'h00006, 20'h00005, 20'h00000, 20'h0ffff, 1'b0, 1'b0, 4'b0100};
    cs[6]  = '{minus_with_carry_op, 1'b0, AM_REG, 20'h00001, 20'h00003, 20'h00001, 20'h0ffff, 1'b1, 1'b0, 4'b0001};
    cs[7]  = '{decimal_sum_op, 1'b0, AM_REG, 20'h00019, 20'h00028, 20'h00048, 20'h0ffff, 1'b1, 1'b0, 4'b0000};
    cs[8]  = '{decimal_sum_op, 1'b0, AM_REG, 20'h00001, 20'h09999, 20'h00000, 20'h0ffff, 1'b1, 1'b0, 4'b0011};
    cs[9]  = '{conjunction_op, 1'b0, AM_REG, 20'h0ff00, 20'h08f0f, 20'h08f00, 20'h0ffff, 1'b1, 1'b0, 4'b0101};
    cs[10] = '{test_mask_op, 1'b0, AM_REG, 20'h000ff, 20'h0ff00, 20'h00000, 20'h0ffff, 1'b0, 1'b0, 4'b0010};
    cs[11] = '{clear_mask_op, 1'b0, AM_REG, 20'h000f0, 20'h012ff, 20'h0120f, 20'h0ffff, 1'b1, 1'b1, 4'b0000};
    cs[12] = '{set_mask_op, 1'b0, AM_REG, 20'h000f0, 20'h01200, 20'h012f0, 20'h0ffff, 1'b1, 1'b1, 4'b0000};
    cs[13] = '{exclusive_or_op, 1'b0, AM_REG, 20'h00001, 20'h08000, 20'h08001, 20'h0ffff, 1'b1, 1'b0, 4'b0101};
    cs[14] = '{exclusive_or_op, 1'b0, AM_REG, 20'h08001, 20'h08000, 20'h00001, 20'h0ffff, 1'b1, 1'b0, 4'b1001};
    cs[15] = '{rotate_right_thru_carry, 1'b0, AM_REG, 20'h00002, 20'h00002, 20'h08001, 20'h0ffff, 1'b1, 1'b0, 4'b0100};
    cs[16] = '{arith_shift_right, 1'b0, AM_REG, 20'h08001, 20'h08001, 20'h0c000, 20'h0ffff, 1'b1, 1'b0, 4'b0101};
    cs[17] = '{byte_swap_op, 1'b0, AM_REG, 20'h01234, 20'h01234, 20'h03412, 20'h0ffff, 1'b1, 1'b1, 4'b0000};
    cs[18] = '{sign_extend_op, 1'b0, AM_REG, 20'h00080, 20'h00080, 20'hfff80, 20'hfffff, 1'b1, 1'b0, 4'b0101};
    cs[19] = '{sign_extend_op, 1'b0, AM_IDX, 20'h00080, 20'h00080, 20'h0ff80, 20'h0ffff, 1'b1, 1'b0, 4'b0101};
    cs[20] = '{sum_op, 1'b1, AM_REG, 20'h00001, 20'h01a7f, 20'h00080, 20'h000ff, 1'b1, 1'b0, 4'b1100};
    cs[21] = '{sum_op, 1'b1, AM_REG, 20'h000ff, 20'h00001, 20'h00000, 20'h000ff, 1'b1, 1'b0, 4'b0011};
    failCount = 0; numChecks = 0; expF = 4'b0000;
    reset = 1'b1; start = 1'b0; opCode = 5'h00; byteMode = 1'b0; srcMode = 3'h0; dstMode = 3'h0;
    srcValue = 20'h00000; dstValue = 20'h00000; stackReadData = 16'h0000;
    popWords[0] = 16'h0000; popWords[1] = 16'h0000;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    t_extra_words();
    t_alu_table();
    t_stack();
    t_subroutine();
    printVerdict();
  end
endmodule // cpu_double_single_operand_ops_test
